//--- rtl/sfp_pkg.sv
package sfp_pkg;

    // ------------------------------------------------------------
    // bus and register map
    // ------------------------------------------------------------
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 32;
    localparam logic [7:0]  ADR_CTRL    = 8'h00;
    localparam logic [7:0]  ADR_ERR     = 8'h04;
    localparam logic [7:0]  ADR_LINE    = 8'h08;
    localparam logic [7:0]  ADR_IRQ_STS = 8'h0C;
    localparam logic [7:0]  ADR_IRQ_CLR = 8'h10;
    localparam logic [7:0]  ADR_IRQ_EN  = 8'h14;

    // control register fields
    localparam int          CTRL_SD_BIT   = 0;
    localparam int          CTRL_PBTL_BIT = 1;
    localparam int          CTRL_FREQ_BIT = 2;
    localparam int          CTRL_GAIN_LSB = 3;
    localparam logic [4:0]  CTRL_RST      = 5'h01;
    localparam logic [5:0]  IRQ_EN_RST    = 6'h00;

    // line/state register fields
    localparam int          LINE_PIN_BIT    = 0;
    localparam int          LINE_HW_BIT     = 1;
    localparam int          LINE_ACTIVE_BIT = 2;
    localparam int          LINE_FAULT_BIT  = 3;
    localparam int          LINE_SDN_BIT    = 4;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_KHZ          = 200000;
    localparam int          FAULT_TIMEOUT_US = 1000;
    localparam int          FAULT_TO_CYC     = FAULT_TIMEOUT_US * CLK_KHZ / 1000;
    localparam int          DC_TIME_MS       = 420;
    localparam int          DC_CYC           = DC_TIME_MS * CLK_KHZ;
    localparam int          CNT_W            = 32;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic ot;
        logic dc;
        logic oc;
        logic clk;
        logic uv;
        logic ov;
    } sfp_err_t;

    typedef struct packed {
        logic [1:0] gain;
        logic       freq_8fs;
        logic       pbtl;
    } sfp_cfg_t;

    typedef struct packed {
        logic ratio_bad;
        logic rate_bad;
        logic stopped;
    } sfp_clkmon_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } sfp_req_t;

    typedef enum logic [0:0] {
        ST_RUN   = 1'b0,
        ST_FAULT = 1'b1
    } sfp_state_t;

endpackage

//--- rtl/sfp_dc_detect.sv
`timescale 1ns/1ps
module sfp_dc_detect
    import sfp_pkg::*;
#(
    parameter int LIMIT = DC_CYC
)(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       srst,
    // duty above 60 percent, per channel and polarity
    input  wire logic [1:0] duty_pos,
    input  wire logic [1:0] duty_neg,
    // level, high while a channel has held dc too long
    output logic            dc_event
);

    logic [CNT_W-1:0] cnt_ff [2];
    logic [1:0]       pol_ff;
    logic [1:0]       hit_ff;

    // ------------------------------------------------------------
    // per channel run-length counter of one polarity
    // ------------------------------------------------------------
    // a change of polarity restarts the run, so slow ac is not dc
    always_ff @(posedge mclk)
    begin
        for (int ch = 0; ch < 2; ch++)
        begin
            if (srst || !(duty_pos[ch] || duty_neg[ch]) || (duty_pos[ch] != pol_ff[ch]))
            begin
                cnt_ff[ch] <= '0;
                hit_ff[ch] <= 1'b0;
            end
            else if (cnt_ff[ch] == LIMIT[CNT_W-1:0])
            begin
                hit_ff[ch] <= 1'b1;
            end
            else
            begin
                cnt_ff[ch] <= cnt_ff[ch] + 1'b1;
            end
        end
    end

    // remember the polarity of the current run
    always_ff @(posedge mclk)
    begin
        if (srst)
            pol_ff <= 2'h0;
        else
            pol_ff <= duty_pos;
    end

    assign dc_event = |hit_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_DC_AFTER_LIMIT: assert property (@(posedge mclk) disable iff (srst)
        $rose(hit_ff[0]) |-> $past(cnt_ff[0]) == LIMIT[CNT_W-1:0])
        else $error("dc event raised before the run limit");

    AST_DC_AFTER_LIMIT_CH1: assert property (@(posedge mclk) disable iff (srst)
        $rose(hit_ff[1]) |-> $past(cnt_ff[1]) == LIMIT[CNT_W-1:0])
        else $error("dc event raised before the run limit");

endmodule

//--- rtl/sfp_fault_ctrl.sv
`timescale 1ns/1ps
// Function
// - fault pin pulled low on amplifier fault in either control mode, else released.
// - latching fault holds pin low until shutdown toggled and timeout elapsed.
// - overvoltage and undervoltage do not drive the pin; playback resumes alone.
// - clock error drives the pin; recovery needs no timeout.
// - overvoltage flagged while supply is above upper threshold.
// - undervoltage flagged while supply is below lower threshold.
// - bad clock ratio, bad rate or stopped clock flags a clock error.
// - overcurrent latches; cleared by timeout plus shutdown toggle.
// - dc detect latches; cleared by timeout plus shutdown toggle.
// - overtemperature latches; also needs temperature below hysteresis to clear.
// - dc event after duty above 60 percent, same polarity, over 420 ms.
// - hardware mode uses defaults changed only by control pins.
// - all static pins low select stereo btl and 768 kHz switching.
// - latching error still present at release is caught again.
// - shutdown low stops the amplifier, high releases it.
// - each error type sets its own status bit.
module sfp_fault_ctrl
    import sfp_pkg::*;
#(
    parameter int TIMEOUT_CYC = FAULT_TO_CYC,
    parameter int DC_LIMIT    = DC_CYC
)(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              srst,
    // register port
    input  wire sfp_req_t          req,
    output logic [DATA_W-1:0]      rdata,
    output logic                   irq,
    // supply, temperature, current, duty and clock monitors
    input  wire logic              supply_over,
    input  wire logic              supply_under,
    input  wire logic              overcurrent,
    input  wire logic              temp_over,
    input  wire logic              temp_below_hyst,
    input  wire logic [1:0]        duty_pos,
    input  wire logic [1:0]        duty_neg,
    input  wire sfp_clkmon_t       clkmon,
    // system pins
    input  wire logic              hw_mode,
    input  wire logic              amp_shutdown_n,
    input  wire sfp_cfg_t          cfg_pins,
    input  wire logic              amp_fault_n_i,
    output logic                   amp_fault_n_o,
    output logic                   amp_fault_n_oe,
    // amplifier controls
    output logic                   amp_active,
    output sfp_cfg_t               cfg
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    sfp_state_t       st_ff;
    sfp_state_t       nxt_st;
    logic [4:0]       ctrl_ff;
    logic [2:0]       latched_ff;
    logic [2:0]       nxt_latched;
    logic [CNT_W-1:0] timer_ff;
    logic             seen_low_ff;
    logic             active_ff;
    logic             nxt_active;
    sfp_cfg_t         cfg_ff;
    sfp_cfg_t         nxt_cfg;
    sfp_err_t         rpt_prev_ff;
    logic [5:0]       irq_sts_ff;
    logic [5:0]       irq_en_ff;
    logic [DATA_W-1:0] rdata_ff;

    logic             dc_hit;
    logic             sd_n;
    logic             clk_err;
    logic             latch_hit;
    logic             timer_done;
    logic             resume;
    sfp_err_t         err_rpt;
    logic [5:0]       irq_ev;
    logic             wr_ctrl;
    logic             wr_clr;
    logic             wr_en;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] line_word;

    // widen a six-bit error vector to a bus word
    function automatic logic [DATA_W-1:0] err_word(input logic [5:0] v);
        err_word = {{(DATA_W-6){1'b0}}, v};
    endfunction

    // ------------------------------------------------------------
    // dc detector
    // ------------------------------------------------------------
    sfp_dc_detect #(
        .LIMIT (DC_LIMIT)
    ) u_dc (
        .mclk     (mclk),
        .srst     (srst),
        .duty_pos (duty_pos),
        .duty_neg (duty_neg),
        .dc_event (dc_hit)
    );

    // ------------------------------------------------------------
    // error classification
    // ------------------------------------------------------------
    // in hardware mode the shutdown bit is ignored, only the pin counts
    assign sd_n       = amp_shutdown_n && (hw_mode || ctrl_ff[CTRL_SD_BIT]);
    assign clk_err    = clkmon.ratio_bad || clkmon.rate_bad || clkmon.stopped;
    assign latch_hit  = (st_ff == ST_RUN) && sd_n
                        && (overcurrent || dc_hit || temp_over);
    assign timer_done = (timer_ff == TIMEOUT_CYC[CNT_W-1:0]);
    // overtemperature also waits for the die to cool below hysteresis
    assign resume     = (st_ff == ST_FAULT) && timer_done && seen_low_ff && sd_n
                        && (!latched_ff[2] || temp_below_hyst);

    // one status bit per error: live for non-latching, held for latching
    assign err_rpt.ov  = supply_over;
    assign err_rpt.uv  = supply_under;
    assign err_rpt.clk = clk_err;
    assign err_rpt.oc  = latched_ff[0];
    assign err_rpt.dc  = latched_ff[1];
    assign err_rpt.ot  = latched_ff[2];

    // ------------------------------------------------------------
    // latch state machine
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st      = st_ff;
        nxt_latched = latched_ff;
        unique case (st_ff)
            ST_RUN:
            begin
                if (latch_hit)
                begin
                    nxt_st      = ST_FAULT;
                    nxt_latched = {temp_over, dc_hit, overcurrent};
                end
            end
            ST_FAULT:
            begin
                if (resume)
                begin
                    nxt_st      = ST_RUN;
                    nxt_latched = 3'h0;
                end
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            st_ff      <= ST_RUN;
            latched_ff <= 3'h0;
        end
        else
        begin
            st_ff      <= nxt_st;
            latched_ff <= nxt_latched;
        end
    end

    // timeout counter starts at detection and saturates at its limit
    always_ff @(posedge mclk)
    begin
        if (srst || latch_hit)
            timer_ff <= '0;
        else if (st_ff == ST_FAULT && !timer_done)
            timer_ff <= timer_ff + 1'b1;
    end

    // a toggle means shutdown was seen low at some point during the fault
    always_ff @(posedge mclk)
    begin
        if (srst || latch_hit)
            seen_low_ff <= 1'b0;
        else if (st_ff == ST_FAULT && !sd_n)
            seen_low_ff <= 1'b1;
    end

    // ------------------------------------------------------------
    // amplifier enable and fault pin
    // ------------------------------------------------------------
    // non-latching errors only pause playback, so no state is kept
    assign nxt_active = sd_n && (st_ff == ST_RUN) && !latch_hit
                        && !supply_over && !supply_under && !clk_err;

    always_ff @(posedge mclk)
    begin
        if (srst)
            active_ff <= 1'b0;
        else
            active_ff <= nxt_active;
    end

    assign amp_active     = active_ff;
    // open drain: only ever drive low, release otherwise
    assign amp_fault_n_o  = 1'b0;
    assign amp_fault_n_oe = (st_ff == ST_FAULT) || clk_err;

    // ------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------
    // pins are static by contract, so no synchroniser is spent on them
    assign nxt_cfg = hw_mode ? cfg_pins
                   : sfp_cfg_t'(ctrl_ff[CTRL_GAIN_LSB+1:CTRL_PBTL_BIT]);

    always_ff @(posedge mclk)
    begin
        if (srst)
            cfg_ff <= '0;
        else
            cfg_ff <= nxt_cfg;
    end

    assign cfg = cfg_ff;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    assign wr_ctrl = req.wr && (req.addr == ADR_CTRL);
    assign wr_clr  = req.wr && (req.addr == ADR_IRQ_CLR);
    assign wr_en   = req.wr && (req.addr == ADR_IRQ_EN);

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ctrl_ff   <= CTRL_RST;
            irq_en_ff <= IRQ_EN_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_ff <= req.wdata[4:0];
            if (wr_en)
                irq_en_ff <= req.wdata[5:0];
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    // rising edge of a status bit is the event; set wins over clear
    assign irq_ev = err_rpt & ~rpt_prev_ff;

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            rpt_prev_ff <= '0;
            irq_sts_ff  <= 6'h00;
        end
        else
        begin
            rpt_prev_ff <= err_rpt;
            irq_sts_ff  <= (irq_sts_ff & ~({6{wr_clr}} & req.wdata[5:0])) | irq_ev;
        end
    end

    assign irq = |(irq_sts_ff & irq_en_ff);

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    assign line_word = err_word({1'b0, sd_n, st_ff == ST_FAULT, active_ff,
                                 hw_mode, amp_fault_n_i});

    assign rd_mux = (req.addr == ADR_CTRL)    ? {{(DATA_W-5){1'b0}}, ctrl_ff} :
                    (req.addr == ADR_ERR)     ? err_word(err_rpt) :
                    (req.addr == ADR_LINE)    ? line_word :
                    (req.addr == ADR_IRQ_STS) ? err_word(irq_sts_ff) :
                    (req.addr == ADR_IRQ_EN)  ? err_word(irq_en_ff) :
                    {DATA_W{1'b0}};

    // data stand for exactly one cycle after the read strobe
    always_ff @(posedge mclk)
    begin
        if (srst || !req.rd)
            rdata_ff <= '0;
        else
            rdata_ff <= rd_mux;
    end

    assign rdata = rdata_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    AST_FAULT_PIN_LOW: assert property (
        st_ff == ST_FAULT |-> amp_fault_n_oe && !amp_fault_n_o)
        else $error("fault pin released during a latched fault");

    AST_HOLD_NO_TOGGLE: assert property (
        st_ff == ST_FAULT && !seen_low_ff |=> st_ff == ST_FAULT)
        else $error("fault left without a shutdown toggle");

    AST_NONLATCH_QUIET: assert property (
        st_ff == ST_RUN && !clk_err |-> !amp_fault_n_oe)
        else $error("pin driven by a non-latching error");

    AST_CLK_NO_WAIT: assert property (
        clk_err ##1 !clk_err && st_ff == ST_RUN && sd_n && !supply_over
        && !supply_under && !latch_hit |=> amp_active)
        else $error("clock recovery waited");

    AST_OV_STOPS: assert property (
        supply_over |=> !amp_active && (!amp_fault_n_oe || st_ff == ST_FAULT || clk_err))
        else $error("overvoltage did not pause playback");

    AST_UV_STOPS: assert property (
        supply_under |=> !amp_active)
        else $error("undervoltage did not pause playback");

    AST_CLK_FLAG: assert property (
        clkmon.stopped || clkmon.rate_bad || clkmon.ratio_bad |-> amp_fault_n_oe)
        else $error("clock fault not signalled");

    AST_TIMEOUT: assert property (
        resume |-> timer_ff == TIMEOUT_CYC[CNT_W-1:0] && seen_low_ff)
        else $error("resume before the timeout");

    AST_OT_HYST: assert property (
        resume && latched_ff[2] |-> temp_below_hyst)
        else $error("overtemperature cleared while still hot");

    AST_REDETECT: assert property (
        st_ff == ST_RUN && sd_n && overcurrent |=> st_ff == ST_FAULT && latched_ff[0])
        else $error("latching error not caught again");

    AST_SHUTDOWN: assert property (
        !amp_shutdown_n |=> !amp_active)
        else $error("amplifier active in shutdown");

    AST_STATUS_BIT: assert property (
        st_ff == ST_FAULT |-> |latched_ff)
        else $error("fault without a status bit");

    AST_HW_CFG: assert property (
        hw_mode |=> cfg == $past(cfg_pins))
        else $error("hardware mode config not from pins");

    COV_LATCH_RECOVER: cover property (
        st_ff == ST_FAULT ##1 resume ##1 st_ff == ST_RUN);
    COV_CLK_FAULT: cover property (clk_err ##1 !clk_err);
    COV_REDETECT: cover property (resume ##1 latch_hit);
    COV_IRQ: cover property ($rose(irq));

endmodule

//--- verification/sfp_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// system processor: watches the fault line, drives the shutdown pin
// ----------------------------------------------------------------
module sfp_host_model
    import sfp_pkg::*;
#(
    parameter int LOW_CYC = 2
)(
    // clock and reset
    input  wire logic mclk,
    input  wire logic srst,
    // fault line on the board and bench commands
    input  wire logic fault_line,
    input  wire logic auto_en,
    input  wire logic cmd_sd_n,
    // shutdown pin, active low
    output logic      amp_shutdown_n
);
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic       sd_ff;

    // auto mode pulses shutdown low on a fault; a plain copy of the fault line
    // would hold shutdown low and the latched fault could never be released
    assign nxt_cnt = (cnt_ff != 8'h00) ? cnt_ff - 8'h01
                   : ((auto_en && !fault_line && sd_ff) ? 8'(LOW_CYC) : 8'h00);

    // shutdown pin changes only just after an edge
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            cnt_ff <= 8'h00;
            sd_ff  <= 1'b1;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            sd_ff  <= auto_en ? (nxt_cnt == 8'h00) : cmd_sd_n;
        end
    end

    assign amp_shutdown_n = sd_ff;
endmodule

//--- verification/tb_speaker_fault_protection.sv
`timescale 1ns/1ps
module tb_speaker_fault_protection
    import sfp_pkg::*;
;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    localparam int TO_CYC = 20;
    localparam int DC_LIM = 16;
    typedef struct packed {
        logic       ov;
        logic       uv;
        logic [2:0] cm;
        logic [5:0] err;
        logic       oe;
    } sfp_row_t;
    sfp_row_t rows [5] = '{
        '{1'b1, 1'b0, 3'h0, 6'h01, 1'b0},   // supply over
        '{1'b0, 1'b1, 3'h0, 6'h02, 1'b0},   // supply under
        '{1'b0, 1'b0, 3'h4, 6'h04, 1'b1},   // bad ratio
        '{1'b0, 1'b0, 3'h2, 6'h04, 1'b1},   // bad rate
        '{1'b0, 1'b0, 3'h1, 6'h04, 1'b1}};  // stopped clock
    logic              mclk;
    logic              srst;
    sfp_req_t          req;
    logic [DATA_W-1:0] rdata;
    logic              irq;
    logic              supply_over;
    logic              supply_under;
    logic              overcurrent;
    logic              temp_over;
    logic              temp_below_hyst;
    logic [1:0]        duty_pos;
    logic [1:0]        duty_neg;
    sfp_clkmon_t       clkmon;
    logic              hw_mode;
    logic              amp_shutdown_n;
    sfp_cfg_t          cfg_pins;
    sfp_cfg_t          cfg;
    logic              fault_line;
    logic              amp_fault_n_o;
    logic              amp_fault_n_oe;
    logic              amp_active;
    logic              auto_en;
    logic              cmd_sd_n;
    logic [31:0]       d;
    int                n_errors;
    int                n_tests;
    int                cycles;

    // board pull-up: the line is low only while the device drives it
    assign fault_line = (amp_fault_n_oe && !amp_fault_n_o) ? 1'b0 : 1'b1;

    sfp_fault_ctrl #(.TIMEOUT_CYC(TO_CYC), .DC_LIMIT(DC_LIM)) dut_u (
        .mclk(mclk), .srst(srst), .req(req), .rdata(rdata), .irq(irq),
        .supply_over(supply_over), .supply_under(supply_under),
        .overcurrent(overcurrent), .temp_over(temp_over),
        .temp_below_hyst(temp_below_hyst), .duty_pos(duty_pos), .duty_neg(duty_neg),
        .clkmon(clkmon), .hw_mode(hw_mode), .amp_shutdown_n(amp_shutdown_n),
        .cfg_pins(cfg_pins), .amp_fault_n_i(fault_line), .amp_fault_n_o(amp_fault_n_o),
        .amp_fault_n_oe(amp_fault_n_oe), .amp_active(amp_active), .cfg(cfg));

    sfp_host_model #(.LOW_CYC(2)) host_u (
        .mclk(mclk), .srst(srst), .fault_line(fault_line), .auto_en(auto_en),
        .cmd_sd_n(cmd_sd_n), .amp_shutdown_n(amp_shutdown_n));

    // ----------------------------------------------------------------
    // clock, hang guard and helpers
    // ----------------------------------------------------------------
    always #2.5 mclk = ~mclk;

    // the whole run needs well under two thousand cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge mclk);
        req.rd   <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        req.addr  <= a;
        req.wdata <= v;
        req.wr    <= 1'b1;
        @(posedge mclk);
        req.wr    <= 1'b0;
        #1;
    endtask

    task automatic wait_oe(input logic v, input int lim);
        int i;
        i = 0;
        while (amp_fault_n_oe !== v && i < lim)
        begin
            cyc(1);
            i++;
        end
        chk1(amp_fault_n_oe, v);
    endtask

    task automatic toggle_sd();
        @(posedge mclk) cmd_sd_n <= 1'b0;
        @(posedge mclk);
        @(posedge mclk) cmd_sd_n <= 1'b1;
        #1;
    endtask

    task automatic set_src(input int k, input logic v);
        @(posedge mclk);
        case (k)
            0: overcurrent <= v;
            1: duty_pos[1] <= v;
            default: temp_over <= v;
        endcase
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        mclk = 0; srst = 1; req = '0; supply_over = 0; supply_under = 0;
        overcurrent = 0; temp_over = 0; temp_below_hyst = 1; duty_pos = 0; duty_neg = 0;
        clkmon = '0; hw_mode = 0; cfg_pins = '0; auto_en = 0; cmd_sd_n = 1;
        n_errors = 0; n_tests = 0; cycles = 0;
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        reg_rd(ADR_CTRL, d);    chk32(d, 32'h0000_0001);
        reg_rd(ADR_IRQ_EN, d);  chk32(d, 32'h0000_0000);
        cyc(2);                 chk1(amp_active, 1'b1);
        reg_rd(ADR_LINE, d);    chk32(d, 32'h0000_0015);
        // non-latching rows: flag while present, automatic recovery
        foreach (rows[i])
        begin
            @(posedge mclk);
            supply_over  <= rows[i].ov;
            supply_under <= rows[i].uv;
            clkmon       <= rows[i].cm;
            cyc(3);
            chk1(amp_fault_n_oe, rows[i].oe);
            chk1(fault_line, !rows[i].oe);
            reg_rd(ADR_ERR, d);     chk32(d, {26'h0, rows[i].err});
            @(posedge mclk);
            supply_over  <= 1'b0;
            supply_under <= 1'b0;
            clkmon       <= '0;
            cyc(3);
            chk1(amp_fault_n_oe, 1'b0);
            chk1(amp_active, 1'b1);
            reg_rd(ADR_ERR, d);     chk32(d, 32'h0);
        end
        // sticky status, masking, clearing, read-only and unmapped places
        reg_rd(ADR_IRQ_STS, d); chk32(d, 32'h0000_0007);
        chk1(irq, 1'b0);
        reg_wr(ADR_IRQ_EN, 32'h1);  chk1(irq, 1'b1);
        reg_wr(ADR_IRQ_CLR, 32'h3F); chk1(irq, 1'b0);
        reg_rd(ADR_IRQ_STS, d); chk32(d, 32'h0);
        reg_wr(ADR_ERR, 32'hFF);
        reg_rd(ADR_ERR, d);     chk32(d, 32'h0);
        reg_rd(8'h20, d);       chk32(d, 32'h0);
        // duty held too briefly, or switching polarity, raises nothing
        @(posedge mclk) duty_pos[0] <= 1'b1;
        cyc(DC_LIM - 4);
        @(posedge mclk) begin duty_pos[0] <= 1'b0; duty_neg[0] <= 1'b1; end
        cyc(DC_LIM - 4);        chk1(amp_fault_n_oe, 1'b0);
        @(posedge mclk) duty_neg[0] <= 1'b0;
        // latching sources: overcurrent, dc detect, overtemperature
        for (int k = 0; k < 3; k++)
        begin
            if (k == 2)
                @(posedge mclk) temp_below_hyst <= 1'b0;
            set_src(k, 1'b1);
            wait_oe(1'b1, DC_LIM + 8);
            reg_rd(ADR_ERR, d);     chk32(d, 32'h8 << k);
            set_src(k, 1'b0);
            cyc(TO_CYC + 5);        chk1(amp_fault_n_oe, 1'b1);
            chk1(amp_active, 1'b0);
            toggle_sd();
            if (k == 2)
            begin
                cyc(5);             chk1(amp_fault_n_oe, 1'b1);
                @(posedge mclk) temp_below_hyst <= 1'b1;
            end
            wait_oe(1'b0, 8);
            cyc(3);                 chk1(amp_active, 1'b1);
        end
        // error still present at release is caught again
        set_src(0, 1'b1);
        wait_oe(1'b1, 4);
        cyc(TO_CYC + 2);
        toggle_sd();
        cyc(5);                 chk1(amp_fault_n_oe, 1'b1);
        reg_rd(ADR_ERR, d);     chk32(d, 32'h8);
        reg_rd(ADR_LINE, d);    chk32(d, 32'h0000_0018);
        set_src(0, 1'b0);
        toggle_sd();
        wait_oe(1'b0, TO_CYC + 8);
        // auto recovery: prompt toggle must still wait for the timeout
        @(posedge mclk) auto_en <= 1'b1;
        set_src(0, 1'b1);
        set_src(0, 1'b0);
        cyc(10);                chk1(amp_fault_n_oe, 1'b1);
        wait_oe(1'b0, TO_CYC + 8);
        @(posedge mclk) auto_en <= 1'b0;
        // shutdown by control bit, then configuration sources
        reg_wr(ADR_CTRL, 32'h0B);
        cyc(3);                 chk1(amp_active, 1'b1);
        chk32({28'h0, cfg}, 32'h5);
        reg_wr(ADR_CTRL, 32'h0A);
        cyc(3);                 chk1(amp_active, 1'b0);
        reg_wr(ADR_CTRL, 32'h01);
        @(posedge mclk) hw_mode <= 1'b1;
        cyc(3);                 chk32({28'h0, cfg}, 32'h0);
        // static pins only move while the amplifier is held in shutdown
        @(posedge mclk) cmd_sd_n <= 1'b0;
        @(posedge mclk) cfg_pins <= 4'hA;
        cyc(3);                 chk32({28'h0, cfg}, 32'hA);
        @(posedge mclk) cmd_sd_n <= 1'b1;
        cyc(3);                 chk1(amp_active, 1'b1);
        complete_run();
    end
endmodule
